// file: core/smp_port.sv
// SRAM-style bus master port: one transaction at a time, stall completes.
// How it works
// - at most one of read, write, sync strobes high
// - same protocol serves instruction or unified port
// - read drives strobe, word address, byte enables
// - byte enables from low address and size
// - unenabled lanes keep old read data
// - done at first sample with wait low
// - status inputs ignored while wait high
// - write drives strobe, address, data, enables
// - outputs held stable while wait high
// - next request starts combinationally after completion
`timescale 1ns/100ps
module smp_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Core request side
    input wire logic req_valid,
    input wire smp_pkg::smp_req_type req,
    output logic req_ready,
    output smp_pkg::smp_rsp_type rsp,
    // Memory agent side
    output smp_pkg::smp_bus_out_type bus_out,
    input wire smp_pkg::smp_bus_in_type bus_in
);
    import smp_pkg::*;

    localparam int LANE_W = DATA_W / LANES;

    // ------------------------------------------------------------
    // Transaction state
    // ------------------------------------------------------------
    typedef enum logic {
        SMP_IDLE,
        SMP_BUSY
    } smp_state_type;

    smp_state_type state_q;
    smp_state_type state_d;
    smp_bus_out_type held_q;
    smp_bus_out_type held_d;
    smp_bus_out_type new_req;
    smp_rsp_type rsp_q;
    smp_rsp_type rsp_d;
    logic [3:0] be_new;
    logic done;
    logic launch;
    logic [3:0] lane_load;
    logic [31:0] rdata_reg;

    // byte enables encode address and size
    always_comb begin
        unique case (req.size)
            SMP_SIZE_BYTE: be_new = BE_BYTE << req.addr[1:0];
            SMP_SIZE_HALF: be_new = BE_HALF << {req.addr[1], 1'b0};
            SMP_SIZE_WORD: be_new = BE_WORD;
            default: be_new = BE_NONE;
        endcase
    end

    // one strobe chosen from the operation
    always_comb begin
        new_req = '0;
        new_req.read = (req.op == SMP_OP_READ);
        new_req.write = (req.op == SMP_OP_WRITE);
        new_req.sync = (req.op == SMP_OP_SYNC);
        new_req.word_addr = req.addr[ADDR_W-1:WADDR_LSB];
        new_req.be = be_new;
        new_req.wdata = req.wdata;
    end

    // completion is the first sample with wait low
    assign done = (state_q == SMP_BUSY) && !bus_in.wait_req;
    // new request only when nothing outstanding
    // wait low lets the next request start at once
    assign req_ready = !srst && ((state_q == SMP_IDLE) || done);
    assign launch = req_valid && req_ready;

    always_comb begin
        state_d = state_q;
        held_d = held_q;
        if (done) begin
            state_d = SMP_IDLE;
            held_d = '0;
        end
        if (launch) begin
            state_d = SMP_BUSY;
            held_d = new_req;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= SMP_IDLE;
            held_q <= '0;
        end else begin
            state_q <= state_d;
            held_q <= held_d;
        end
    end

    // ------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------
    // read carries strobe, word address and enables
    // held register keeps outputs stable during wait
    // strobes are low from the cycle after reset is first sampled high
    assign bus_out = (state_q == SMP_BUSY) ? held_q : '0;

    // ------------------------------------------------------------
    // Read data input register
    // ------------------------------------------------------------
    // only lanes with input enable load; others keep value
    assign lane_load = (done && held_q.read) ? bus_in.rbe : BE_NONE;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            smp_lane_reg #(.W(LANE_W)) u_lane (
                .clk_sys(clk_sys),
                .srst(srst),
                .load(lane_load[g]),
                .din(bus_in.rdata[g*LANE_W +: LANE_W]),
                .dout(rdata_reg[g*LANE_W +: LANE_W])
            );
        end
    endgenerate

    // status is only taken when wait is low
    always_comb begin
        rsp_d = '0;
        rsp_d.op = rsp_q.op;
        if (done) begin
            rsp_d.done = 1'b1;
            rsp_d.op = held_q.write ? SMP_OP_WRITE :
                (held_q.sync ? SMP_OP_SYNC : SMP_OP_READ);
            rsp_d.bus_error = bus_in.bus_error;
            rsp_d.redirect = bus_in.redirect;
            rsp_d.abort_ack = bus_in.abort_ack;
            rsp_d.unlock_ack = bus_in.unlock_ack;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    always_comb begin
        rsp = rsp_q;
        rsp.rdata = rdata_reg;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_stalled;
        (bus_out.read || bus_out.write || bus_out.sync) && bus_in.wait_req;
    endsequence

    chk_one_strobe: assert property (@(posedge clk_sys) disable iff (srst)
        $onehot0({bus_out.read, bus_out.write, bus_out.sync}))
        else $error("More than one strobe high.");

    chk_hold_stall: assert property (@(posedge clk_sys) disable iff (srst)
        s_stalled |=> $stable(bus_out))
        else $error("Outputs changed during wait.");

    chk_no_rst_strobe: assert property (@(posedge clk_sys)
        srst |=> !(bus_out.read || bus_out.write || bus_out.sync))
        else $error("Strobe after reset cycle.");

    chk_status_gate: assert property (@(posedge clk_sys) disable iff (srst)
        s_stalled |=> !rsp.done && !rsp.bus_error && !rsp.redirect
        && !rsp.abort_ack && !rsp.unlock_ack)
        else $error("Status taken during wait.");

    chk_done_next: assert property (@(posedge clk_sys) disable iff (srst)
        (bus_out.read || bus_out.write || bus_out.sync) && !bus_in.wait_req
        |=> rsp.done)
        else $error("Completion not reported.");

    chk_lane_keep: assert property (@(posedge clk_sys) disable iff (srst)
        done && held_q.read && !bus_in.rbe[0]
        |=> $stable(rsp.rdata[7:0]))
        else $error("Unenabled lane changed.");

    chk_lane_load: assert property (@(posedge clk_sys) disable iff (srst)
        done && held_q.read && bus_in.rbe[3]
        |=> rsp.rdata[31:24] == $past(bus_in.rdata[31:24]))
        else $error("Enabled lane not loaded.");

    chk_word_addr: assert property (@(posedge clk_sys) disable iff (srst)
        launch |=> bus_out.word_addr == $past(req.addr[31:2])
        && bus_out.be == $past(be_new))
        else $error("Address or enables wrong.");

    chk_wdata: assert property (@(posedge clk_sys) disable iff (srst)
        launch && req.op == SMP_OP_WRITE
        |=> bus_out.write && bus_out.wdata == $past(req.wdata))
        else $error("Write data wrong.");

    chk_word_be: assert property (@(posedge clk_sys) disable iff (srst)
        launch && req.size == SMP_SIZE_WORD |=> bus_out.be == BE_WORD)
        else $error("Word access enables wrong.");

    chk_back2back: assert property (@(posedge clk_sys) disable iff (srst)
        done && req_valid |=> (bus_out.read || bus_out.write
        || bus_out.sync))
        else $error("Next request not started.");

    chk_one_outst: assert property (@(posedge clk_sys) disable iff (srst)
        s_stalled |-> !req_ready)
        else $error("Request taken while busy.");
endmodule

// file: common/smp_pkg.sv
// Package with shared types and constants for the SRAM-style master port.
package smp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int WADDR_LSB = 2;

    // ------------------------------------------------------------
    // Access sizes and constants
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SMP_SIZE_BYTE,
        SMP_SIZE_HALF,
        SMP_SIZE_WORD
    } smp_size_type;

    typedef enum logic [1:0] {
        SMP_OP_READ,
        SMP_OP_WRITE,
        SMP_OP_SYNC
    } smp_op_type;

    localparam logic [3:0] BE_NONE = 4'h0;
    localparam logic [3:0] BE_BYTE = 4'h1;
    localparam logic [3:0] BE_HALF = 4'h3;
    localparam logic [3:0] BE_WORD = 4'hf;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [29:0] WADDR_RESET = 30'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        smp_op_type op;
        smp_size_type size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } smp_req_type;

    typedef struct packed {
        logic read;
        logic write;
        logic sync;
        logic [29:0] word_addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } smp_bus_out_type;

    typedef struct packed {
        logic wait_req;
        logic [31:0] rdata;
        logic [3:0] rbe;
        logic bus_error;
        logic redirect;
        logic abort_ack;
        logic unlock_ack;
    } smp_bus_in_type;

    typedef struct packed {
        logic done;
        smp_op_type op;
        logic [31:0] rdata;
        logic bus_error;
        logic redirect;
        logic abort_ack;
        logic unlock_ack;
    } smp_rsp_type;

endpackage

// file: core/smp_lane_reg.sv
// One byte lane of the read-data input register.
`timescale 1ns/100ps
module smp_lane_reg #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Lane data
    input wire logic load,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    import smp_pkg::*;

    logic [W-1:0] lane_q;
    logic [W-1:0] lane_d;

    always_comb begin
        lane_d = lane_q;
        if (load) begin
            lane_d = din;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lane_q <= '0;
        end else begin
            lane_q <= lane_d;
        end
    end

    assign dout = lane_q;
endmodule

// file: verification/smp_mem_agent.sv
// Memory agent model with programmable waitstates.
`timescale 1ns/100ps
module smp_mem_agent (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Bench control
    input wire logic [3:0] waits,
    input wire logic bad_rbe,
    input wire logic flag_err,
    // Bus
    input wire smp_pkg::smp_bus_out_type bus_out,
    output smp_pkg::smp_bus_in_type bus_in
);
    import smp_pkg::*;
    logic [31:0] mem [16];
    logic [3:0] cnt_q;
    logic [3:0] a;
    logic act;
    logic fin;
    assign a = bus_out.word_addr[3:0];
    assign act = bus_out.read | bus_out.write | bus_out.sync;
    assign fin = act && cnt_q >= waits;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 32'h0101_0101 * i;
    end
    // request sampled at edge, enabled lanes only
    always @(posedge clk_sys) begin
        cnt_q <= (srst || !act || fin) ? 4'h0 : cnt_q + 4'h1;
        for (int g = 0; g < 4; g++) begin
            if (fin && bus_out.write && bus_out.be[g]) begin
                mem[a][8*g+:8] <= bus_out.wdata[8*g+:8];
            end
        end
    end
    // lanes and status; junk outside completion.
    always_comb begin
        bus_in.wait_req = act && !fin;
        bus_in.rdata = ~mem[a];
        bus_in.rbe = fin ? 4'h0 : 4'hf;
        if (fin && bus_out.read) begin
            bus_in.rdata = mem[a];
            bus_in.rbe = bad_rbe ? 4'h0 : bus_out.be;
        end
        bus_in.bus_error = !fin || flag_err;
        bus_in.redirect = !fin || flag_err;
        bus_in.abort_ack = !fin || flag_err;
        bus_in.unlock_ack = !fin || flag_err;
    end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the SRAM-style master port.
`timescale 1ns/100ps
module testbench;
    import smp_pkg::*;
    typedef struct packed {
        smp_op_type op;
        smp_size_type size;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] waits;
        logic [3:0] be;
        logic [31:0] rdata;
    } smp_row_type;
    localparam int NR = 8;
    smp_row_type rows [NR] = '{
    '{SMP_OP_WRITE, SMP_SIZE_WORD, 32'h10, 32'h1122_3344, 4'h0, 4'hf, 32'h0},
    '{SMP_OP_WRITE, SMP_SIZE_BYTE, 32'h11, 32'h5566_7788, 4'h1, 4'h2, 32'h0},
    '{SMP_OP_READ, SMP_SIZE_WORD, 32'h10, 32'h0, 4'h0, 4'hf, 32'h1122_7744},
    '{SMP_OP_READ, SMP_SIZE_HALF, 32'h16, 32'h0, 4'h2, 4'hc, 32'h0505_7744},
    '{SMP_OP_READ, SMP_SIZE_BYTE, 32'h03, 32'h0, 4'h3, 4'h8, 32'h0005_7744},
    '{SMP_OP_SYNC, SMP_SIZE_WORD, 32'h20, 32'h0, 4'h1, 4'hf, 32'h0005_7744},
    '{SMP_OP_READ, SMP_SIZE_HALF, 32'h14, 32'h0, 4'h0, 4'h3, 32'h0005_0505},
    '{SMP_OP_READ, SMP_SIZE_BYTE, 32'h19, 32'h0, 4'h0, 4'h2, 32'h0005_0605}};
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    smp_req_type req = '0;
    logic req_ready;
    smp_rsp_type rsp;
    smp_bus_out_type bus_out;
    smp_bus_in_type bus_in;
    logic [3:0] waits = 4'h0;
    logic bad_rbe = 1'b0;
    logic flag_err = 1'b0;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    smp_rsp_type rq [$];
    smp_bus_out_type bq [$];
    smp_bus_out_type prev;
    smp_rsp_type s;
    smp_bus_out_type b;
    logic held = 1'b0;
    logic fin_prev = 1'b0;
    logic rst_prev = 1'b0;
    logic act;
    assign act = bus_out.read | bus_out.write | bus_out.sync;
    always #50 clk_sys = ~clk_sys;
    smp_port smp_port_i (.clk_sys(clk_sys), .srst(srst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp(rsp), .bus_out(bus_out), .bus_in(bus_in));
    smp_mem_agent smp_mem_agent_i (.clk_sys(clk_sys), .srst(srst),
        .waits(waits), .bad_rbe(bad_rbe), .flag_err(flag_err),
        .bus_out(bus_out), .bus_in(bus_in));
    task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
        checked++;
        if (e !== g) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ----
    // Monitor on the settled values before each edge.
    // ----
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 2000) begin
            n_fail++;
            tally_and_finish();
        end
        cmp("one_hot", 1, {31'h0, $countones({bus_out[68:66]}) <= 1});
        if (held) cmp("hold", 1, {31'h0, bus_out === prev});
        if (srst && rst_prev) cmp("rst_strobe", 0, bus_out[68:66]);
        if (!srst) cmp("done", fin_prev, rsp.done);
        if (rsp.done === 1'b1) rq.push_back(rsp);
        if (act && bus_in.wait_req === 1'b0) bq.push_back(bus_out);
        prev = bus_out;
        held = !srst && act && bus_in.wait_req === 1'b1;
        fin_prev = !srst && act && bus_in.wait_req === 1'b0;
        rst_prev = srst;
    end
    task automatic issue(smp_row_type r);
        int n;
        n = 0;
        req_valid = 1'b1;
        req = '{r.op, r.size, r.addr, r.wdata};
        #1;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            #1;
            n++;
        end
        cmp("ready", 1, {31'h0, n < 50});
        @(negedge clk_sys);
        waits = r.waits;
    endtask
    task automatic drain(int k);
        int n;
        n = 0;
        req_valid = 1'b0;
        while (rq.size() < k && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        cmp("drained", 1, {31'h0, rq.size() >= k});
    endtask
    task automatic run1(smp_row_type r);
        issue(r);
        drain(1);
        s = rq.size() != 0 ? rq.pop_front() : '0;
        bq.delete();
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        foreach (rows[i]) issue(rows[i]);
        drain(NR);
        foreach (rows[i]) begin
            s = rq.pop_front();
            b = bq.pop_front();
            cmp("op", rows[i].op, s.op);
            cmp("rdata", rows[i].rdata, s.rdata);
            cmp("status", 0, {s.bus_error, s.redirect, s.abort_ack, s.unlock_ack});
            cmp("addr", rows[i].addr[31:2], b.word_addr);
            cmp("be", rows[i].be, b.be);
            cmp("strobe", 3'h1 << rows[i].op, {b.sync, b.write, b.read});
            if (rows[i].op == SMP_OP_WRITE) cmp("wdata", rows[i].wdata, b.wdata);
        end
        cmp("idle", 0, bus_out[68:66]);
        // ----
        // Faulty agent, status at completion, reset mid-transfer.
        // ----
        bad_rbe = 1'b1;
        run1('{SMP_OP_READ, SMP_SIZE_WORD, 32'h10, 32'h0, 4'h0, 4'hf, 32'h0});
        cmp("rbe_keep", 32'h0005_0605, s.rdata);
        bad_rbe = 1'b0;
        flag_err = 1'b1;
        run1('{SMP_OP_READ, SMP_SIZE_BYTE, 32'h10, 32'h0, 4'h1, 4'h1, 32'h0});
        flag_err = 1'b0;
        cmp("err_rdata", 32'h0005_0644, s.rdata);
        cmp("err_status", 4'hf, {s.bus_error, s.redirect, s.abort_ack, s.unlock_ack});
        issue('{SMP_OP_READ, SMP_SIZE_WORD, 32'h14, 32'h0, 4'h5, 4'hf, 32'h0});
        req_valid = 1'b0;
        repeat (2) @(negedge clk_sys);
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        cmp("rst_bus", 0, bus_out[68:66]);
        cmp("rst_rdata", 0, rsp.rdata);
        waits = 4'h0;
        run1('{SMP_OP_READ, SMP_SIZE_WORD, 32'h14, 32'h0, 4'h0, 4'hf, 32'h0});
        cmp("post_rst", 32'h0505_0505, s.rdata);
        tally_and_finish();
    end
endmodule
